/* core/sfs_flash_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_dev
  import sfs_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC,
  parameter int PAGE_CYCLES = PAGE_CYC,
  parameter int SECT_CYCLES = SECT_CYC,
  parameter int ARR_CYCLES = ARR_CYC
) (
  // clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst,
  // serial link
  sfs_link_if.dev                link,
  // protection setting and flags
  input  wire logic [2:0]        protect_sel,
  output logic                   cycle_running_flag,
  output logic                   write_unlock_latch,
  // array inspection port
  input  wire logic [MEM_AW-1:0] rd_addr,
  output logic [7:0]             rd_data
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_WALK = 3'b010,
    D_WAIT = 3'b100
  } sfs_dstate_type;
  typedef enum logic [1:0] {C_PAGE, C_SECT, C_ARR} sfs_cop_type;

  function automatic logic is_prot(input logic [2:0] bp, input logic [1:0] sect);
    case (bp)
      BP_NONE: is_prot = 1'b0;
      BP_TOP1: is_prot = (sect == SECT_LAST);
      BP_TOP2: is_prot = (sect >= SECT_HALF);
      default: is_prot = 1'b1;
    endcase
  endfunction : is_prot

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] cs_q;
  logic [2:0] sk_q;
  logic [1:0] mo_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_q <= 3'h7;
      sk_q <= 3'h0;
      mo_q <= 2'h0;
    end else begin
      cs_q <= {cs_q[1:0], link.cs_n};
      sk_q <= {sk_q[1:0], link.sclk};
      mo_q <= {mo_q[0], link.mosi};
    end
  end
  wire logic sel     = ~cs_q[1];
  wire logic cs_fall = ~cs_q[1] & cs_q[2];
  wire logic cs_rise = cs_q[1] & ~cs_q[2];
  wire logic sk_rise = sel & sk_q[1] & ~sk_q[2];
  wire logic sk_fall = sel & ~sk_q[1] & sk_q[2];

  ////////////////////////////////////////////////////////////////////////
  // frame receiver
  logic [2:0]            bit_r;
  logic [2:0]            byte_r;
  logic [6:0]            sh_r;
  logic [7:0]            op_r;
  logic [23:0]           addr_r;
  logic [7:0]            pidx_r;
  logic                  frame_ok_r;
  logic [7:0]            pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_r;
  logic                  busy_r;
  logic                  pu_done_r;
  wire logic [7:0]       rx_byte = {sh_r, mo_q[1]};
  wire logic             byte_done = sk_rise & (bit_r == BIT_LAST);

  always_ff @(posedge clk) begin
    if (rst | cs_fall) begin
      bit_r  <= 3'h0;
      byte_r <= 3'h0;
    end else if (sk_rise) begin
      sh_r  <= rx_byte[6:0];
      bit_r <= bit_r + 3'h1;
      if (byte_done && byte_r != BC_DATA)
        byte_r <= byte_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_r   <= 8'h0;
      addr_r <= 24'h0;
      pidx_r <= 8'h0;
    end else if (byte_done) begin
      if (byte_r == 3'h0)
        op_r <= rx_byte;
      else if (byte_r < BC_ADDR)
        addr_r <= {addr_r[15:0], rx_byte};
      if (byte_r == BC_ADDR - 3'h1)
        pidx_r <= rx_byte;
      else if (byte_r >= BC_ADDR)
        pidx_r <= pidx_r + 8'h1;
    end
  end

  // page buffer is frozen while a cycle walks it; frames begun busy capture nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_ok_r <= 1'b0;
      valid_r    <= '0;
    end else if (cs_fall) begin
      frame_ok_r <= ~busy_r;
      if (!busy_r)
        valid_r <= '0;
    end else if (byte_done && byte_r >= BC_ADDR && op_r == OP_PAGE && frame_ok_r) begin
      valid_r[pidx_r] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (byte_done && byte_r >= BC_ADDR && op_r == OP_PAGE && frame_ok_r)
      pbuf[pidx_r] <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction decode at select rise
  logic [TW-1:0] pu_cnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pu_cnt_r  <= '0;
      pu_done_r <= 1'b0;
    end else if (!pu_done_r) begin
      pu_cnt_r  <= pu_cnt_r + 1'b1;
      pu_done_r <= (pu_cnt_r == TW'(PUW_CYCLES - 1));
    end
  end

  wire logic       aligned = (bit_r == 3'h0);
  wire logic       wr_ok   = cs_rise & aligned & pu_done_r & ~busy_r & frame_ok_r;
  wire logic [1:0] sect    = addr_r[MEM_AW-1:SECT_AW];
  wire logic go_page = wr_ok & write_unlock_latch & (op_r == OP_PAGE)
                     & (byte_r == BC_DATA) & ~is_prot(protect_sel, sect);
  wire logic go_sect = wr_ok & write_unlock_latch & (op_r == OP_SECTOR)
                     & (byte_r == BC_ADDR) & ~is_prot(protect_sel, sect);
  wire logic go_arr  = wr_ok & write_unlock_latch & (op_r == OP_ARRAY)
                     & (byte_r == BC_OPC) & (protect_sel == BP_NONE);
  wire logic go_any  = go_page | go_sect | go_arr;

  always_ff @(posedge clk) begin
    if (rst)
      write_unlock_latch <= 1'b0;
    else if (go_any)
      write_unlock_latch <= 1'b0;
    else if (wr_ok && op_r == OP_UNLOCK && byte_r == BC_OPC)
      write_unlock_latch <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed cycle
  sfs_dstate_type    st_r;
  sfs_cop_type       cop_r;
  logic [MEM_AW-1:0] base_r;
  logic [MEM_AW-1:0] last_r;
  logic [MEM_AW-1:0] idx_r;
  logic [TW-1:0]     tmr_r;
  logic [7:0]        mem [MEM_BYTES];

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= D_IDLE;
      cop_r  <= C_PAGE;
      base_r <= '0;
      last_r <= '0;
      idx_r  <= '0;
      tmr_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      case (st_r)
        D_IDLE: if (go_any) begin
          st_r   <= D_WALK;
          busy_r <= 1'b1;
          idx_r  <= '0;
          if (go_page) begin
            cop_r  <= C_PAGE;
            base_r <= {addr_r[MEM_AW-1:8], 8'h0};
            last_r <= MEM_AW'(PAGE_BYTES - 1);
            tmr_r  <= TW'(PAGE_CYCLES);
          end else if (go_sect) begin
            cop_r  <= C_SECT;
            base_r <= {sect, {SECT_AW{1'b0}}};
            last_r <= {2'h0, {SECT_AW{1'b1}}};
            tmr_r  <= TW'(SECT_CYCLES);
          end else begin
            cop_r  <= C_ARR;
            base_r <= '0;
            last_r <= MEM_AW'(MEM_BYTES - 1);
            tmr_r  <= TW'(ARR_CYCLES);
          end
        end
        D_WALK: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == last_r)
            st_r <= D_WAIT;
        end
        D_WAIT: begin
          tmr_r <= tmr_r - 1'b1;
          if (tmr_r <= TW'(1)) begin
            st_r   <= D_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: st_r <= D_IDLE;
      endcase
    end
  end
  assign cycle_running_flag = busy_r;

  // array contents survive reset like real flash cells; a page program only clears bits
  wire logic [MEM_AW-1:0] waddr = base_r + idx_r;
  always_ff @(posedge clk) begin
    if (st_r == D_WALK) begin
      if (cop_r != C_PAGE)
        mem[waddr] <= 8'hff;
      else if (valid_r[idx_r[7:0]])
        mem[waddr] <= mem[waddr] & pbuf[idx_r[7:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      rd_data <= 8'h0;
    else
      rd_data <= mem[rd_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // signature output, repeated every eight serial clocks
  wire logic sig_phase = sel & (op_r == OP_SIG) & (byte_r >= BC_ADDR);
  always_ff @(posedge clk) begin
    if (rst || !sel) begin
      link.miso    <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (sk_fall && sig_phase) begin
      link.miso    <= SIG_VALUE[3'h7 - bit_r];
      link.miso_oe <= 1'b1;
    end
  end
endmodule : sfs_flash_dev
`default_nettype wire

/* pkg/sfs_pkg.sv */
package sfs_pkg;
  // opcodes and signature: arbitrary values
  localparam logic [7:0] OP_UNLOCK  = 8'h11;
  localparam logic [7:0] OP_PAGE    = 8'h22;
  localparam logic [7:0] OP_SECTOR  = 8'h33;
  localparam logic [7:0] OP_ARRAY   = 8'h44;
  localparam logic [7:0] OP_SIG     = 8'h55;
  localparam logic [7:0] SIG_VALUE  = 8'h5a;
  // array geometry (small model)
  localparam int         MEM_AW     = 12;
  localparam int         MEM_BYTES  = 4096;
  localparam int         PAGE_BYTES = 256;
  localparam int         SECT_AW    = 10;
  localparam logic [2:0] BP_NONE    = 3'h0;
  localparam logic [2:0] BP_TOP1    = 3'h1;
  localparam logic [2:0] BP_TOP2    = 3'h2;
  localparam logic [1:0] SECT_LAST  = 2'h3;
  localparam logic [1:0] SECT_HALF  = 2'h2;
  // frame byte counts
  localparam logic [2:0] BC_OPC     = 3'h1;
  localparam logic [2:0] BC_ADDR    = 3'h4;
  localparam logic [2:0] BC_DATA    = 3'h5;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  // timing at 25 MHz
  localparam int         CLK_KHZ    = 25000;
  localparam int         PUW_US     = 1000;
  localparam int         PUW_CYC    = (PUW_US * CLK_KHZ + 999) / 1000;
  localparam int         VSL_US     = 30;
  localparam int         VSL_CYC    = (VSL_US * CLK_KHZ + 999) / 1000;
  localparam int         PAGE_CYC   = 64;
  localparam int         SECT_CYC   = 128;
  localparam int         ARR_CYC    = 256;
  localparam int         HALF_CYC   = 8;
  localparam int         TW         = 24;
  // host registers
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_TX     = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0c;
  localparam logic [7:0] REG_RX     = 8'h10;
  localparam int         CTL_AN_LO  = 8;
  localparam int         CTL_DN_LO  = 10;
  localparam int         CTL_RD     = 20;
endpackage : sfs_pkg

/* pkg/sfs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfs_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // pulled high when the device lets go of its output
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev  (input cs_n, sclk, mosi, output miso, miso_oe);
  modport host (output cs_n, sclk, mosi, input miso_line);
endinterface : sfs_link_if
`default_nettype wire

/* core/sfs_host_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_host_ctrl
  import sfs_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [31:0]     reg_rdata,
  // serial link
  sfs_link_if.host        link
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LOAD = 5'b00010,
    H_LOW  = 5'b00100,
    H_HIGH = 5'b01000,
    H_END  = 5'b10000
  } sfs_hstate_type;

  function automatic logic is_write_op(input logic [7:0] op);
    is_write_op = (op == OP_UNLOCK) | (op == OP_PAGE) | (op == OP_SECTOR) | (op == OP_ARRAY);
  endfunction : is_write_op

  sfs_hstate_type st_r;
  logic [1:0]     mi_q;
  logic [TW-1:0]  pu_cnt_r;
  logic           sel_ok_r;
  logic           wr_ok_r;
  logic [7:0]     op_r;
  logic [1:0]     an_r;
  logic           rd_r;
  logic [23:0]    addr_r;
  logic [7:0]     tx_r;
  logic           tx_full_r;
  logic [7:0]     rx_r;
  logic           rx_valid_r;
  logic [7:0]     sh_r;
  logic [7:0]     rsh_r;
  logic [2:0]     bit_r;
  logic [11:0]    bidx_r;
  logic [11:0]    total_r;
  logic [4:0]     cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // power-up gates
  always_ff @(posedge clk) begin
    if (rst) begin
      pu_cnt_r <= '0;
      sel_ok_r <= 1'b0;
      wr_ok_r  <= 1'b0;
    end else begin
      if (!wr_ok_r || !sel_ok_r)
        pu_cnt_r <= pu_cnt_r + 1'b1;
      if (pu_cnt_r == TW'(VSL_CYC - 1))
        sel_ok_r <= 1'b1;
      if (pu_cnt_r == TW'(PUW_CYCLES - 1))
        wr_ok_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  wire logic start = reg_wr & (reg_addr == REG_CTRL) & (st_r == H_IDLE) & sel_ok_r
                   & (wr_ok_r | ~is_write_op(reg_wdata[7:0]));
  wire logic take_tx = (st_r == H_LOAD) & (bidx_r > {10'h0, an_r}) & ~rd_r & tx_full_r;
  wire logic got_rx  = (st_r == H_HIGH) & (cnt_r == 5'(HALF_CYC - 1)) & (bit_r == BIT_LAST)
                     & rd_r & (bidx_r > {10'h0, an_r});

  always_ff @(posedge clk) begin
    if (rst) begin
      op_r   <= 8'h0;
      an_r   <= 2'h0;
      rd_r   <= 1'b0;
      addr_r <= 24'h0;
      tx_r   <= 8'h0;
    end else begin
      if (start) begin
        op_r <= reg_wdata[7:0];
        an_r <= reg_wdata[CTL_DN_LO-1:CTL_AN_LO];
        rd_r <= reg_wdata[CTL_RD];
      end
      if (reg_wr && reg_addr == REG_ADDR)
        addr_r <= reg_wdata[23:0];
      if (reg_wr && reg_addr == REG_TX)
        tx_r <= reg_wdata[7:0];
    end
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_full_r  <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_r       <= 8'h0;
    end else begin
      if (reg_wr && reg_addr == REG_TX)
        tx_full_r <= 1'b1;
      else if (take_tx)
        tx_full_r <= 1'b0;
      if (got_rx) begin
        rx_valid_r <= 1'b1;
        rx_r       <= rsh_r;
      end else if (reg_rd && reg_addr == REG_RX) begin
        rx_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd) begin
      case (reg_addr)
        REG_ADDR: reg_rdata <= {8'h0, addr_r};
        REG_STAT: reg_rdata <= {27'h0, wr_ok_r, sel_ok_r, rx_valid_r, tx_full_r, st_r != H_IDLE};
        REG_RX:   reg_rdata <= {24'h0, rx_r};
        default:  reg_rdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame engine, clock idles low, data changes while it is low
  always_ff @(posedge clk) begin
    if (rst)
      mi_q <= 2'h3;
    else
      mi_q <= {mi_q[0], link.miso_line};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      sh_r      <= 8'h0;
      rsh_r     <= 8'h0;
      bit_r     <= 3'h0;
      bidx_r    <= 12'h0;
      total_r   <= 12'h0;
      cnt_r     <= 5'h0;
    end else begin
      case (st_r)
        H_IDLE: if (start) begin
          st_r    <= H_LOAD;
          bidx_r  <= 12'h0;
          total_r <= 12'h1 + {10'h0, reg_wdata[CTL_DN_LO-1:CTL_AN_LO]}
                   + {2'h0, reg_wdata[CTL_RD-1:CTL_DN_LO]};
        end
        H_LOAD: begin
          link.cs_n <= 1'b0;
          cnt_r     <= 5'h0;
          bit_r     <= 3'h0;
          if (bidx_r == 12'h0 || bidx_r <= {10'h0, an_r} || rd_r || tx_full_r)
            st_r <= H_LOW;
          if (bidx_r == 12'h0) begin
            sh_r      <= op_r;
            link.mosi <= op_r[7];
          end else if (bidx_r <= {10'h0, an_r}) begin
            sh_r      <= 8'(addr_r >> (5'(an_r - bidx_r[1:0]) << 3));
            link.mosi <= addr_r[5'(an_r - bidx_r[1:0]) * 5'h8 + 5'h7];
          end else begin
            sh_r      <= rd_r ? 8'h0 : tx_r;
            link.mosi <= ~rd_r & tx_r[7];
          end
        end
        H_LOW: begin
          link.mosi <= sh_r[7];
          cnt_r     <= cnt_r + 5'h1;
          if (cnt_r == 5'(HALF_CYC - 1)) begin
            link.sclk <= 1'b1;
            rsh_r     <= {rsh_r[6:0], mi_q[1]};
            cnt_r     <= 5'h0;
            st_r      <= H_HIGH;
          end
        end
        H_HIGH: begin
          cnt_r <= cnt_r + 5'h1;
          if (cnt_r == 5'(HALF_CYC - 1)) begin
            link.sclk <= 1'b0;
            cnt_r     <= 5'h0;
            if (bit_r == BIT_LAST) begin
              bidx_r <= bidx_r + 12'h1;
              st_r   <= (bidx_r + 12'h1 == total_r) ? H_END : H_LOAD;
            end else begin
              bit_r <= bit_r + 3'h1;
              sh_r  <= {sh_r[6:0], 1'b0};
              st_r  <= H_LOW;
            end
          end
        end
        H_END: begin
          cnt_r <= cnt_r + 5'h1;
          if (cnt_r == 5'(HALF_CYC - 1))
            link.cs_n <= 1'b1;
          if (cnt_r == 5'(2 * HALF_CYC - 1))
            st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule : sfs_host_ctrl
`default_nettype wire

/* bench/sfs_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  // device flags
  input wire logic cycle_running_flag,
  input wire logic write_unlock_latch
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_sclk_pulse;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_latch_drop;
    $past(write_unlock_latch, 2) && !write_unlock_latch;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  property p_reset_idle;
    $fell(rst) |-> cs_n && !sclk && !miso_oe && !cycle_running_flag && !write_unlock_latch;
  endproperty
  property p_idle_clock_low;
    cs_n |-> !sclk;
  endproperty
  property p_mosi_steady;
    sclk |-> $stable(mosi);
  endproperty
  property p_sclk_width;
    $rose(sclk) |-> s_sclk_pulse;
  endproperty
  property p_start_on_release;
    $rose(cycle_running_flag) |-> cs_n && $past(cs_n);
  endproperty
  property p_latch_cleared;
    $rose(cycle_running_flag) |-> s_latch_drop;
  endproperty
  property p_cycle_min;
    $rose(cycle_running_flag) |=> cycle_running_flag [*8];
  endproperty
  property p_latch_set_on_release;
    $rose(write_unlock_latch) |-> cs_n;
  endproperty
  property p_sig_release;
    $rose(cs_n) |-> ##[1:6] !miso_oe;
  endproperty
  // bits only move on falling edges, so a high clock must see a steady line
  property p_miso_steady;
    miso_oe && $past(miso_oe) && sclk |-> $stable(miso);
  endproperty
  //////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
  a_idle_clock_low: assert property (p_idle_clock_low) else $error("clock moved while deselected");
  a_mosi_steady: assert property (p_mosi_steady) else $error("mosi moved while clock high");
  a_sclk_width: assert property (p_sclk_width) else $error("clock high phase wrong length");
  a_start_on_release: assert property (p_start_on_release) else $error("cycle began while selected");
  a_latch_cleared: assert property (p_latch_cleared) else $error("cycle began without latch drop");
  a_cycle_min: assert property (p_cycle_min) else $error("cycle flag too short");
  a_latch_set_on_release: assert property (p_latch_set_on_release) else $error("latch set while selected");
  a_sig_release: assert property (p_sig_release) else $error("output kept after deselect");
  a_miso_steady: assert property (p_miso_steady) else $error("miso moved while clock high");
endmodule : sfs_link_assertions
`default_nettype wire

/* bench/serial_flash_program_erase_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_program_erase_sequencer_tb_top import sfs_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0]  protect_sel = 3'h0;
  logic [11:0] rd_addr = 12'h000;
  logic [7:0]  rd_data;
  logic        cycle_running_flag;
  logic        write_unlock_latch;
  logic [7:0]  txq[$];
  logic [7:0]  rxq[$];
  logic [7:0]  bad_op[4] = '{OP_SECTOR, OP_ARRAY, OP_PAGE, OP_SECTOR};
  int          bad_ab[4] = '{3, 1, 3, 2};
  int          bad_nd[4] = '{1, 0, 0, 0};
  int          fails = 0;
  int          total_checks = 0;
  always #20 clk = ~clk;
  sfs_link_if lnk ();
  // device write delay longer than the host's, so an early unlock reaches it
  sfs_flash_dev #(.PUW_CYCLES(1200), .PAGE_CYCLES(32), .SECT_CYCLES(32), .ARR_CYCLES(32)) u_sfs_flash_dev (
    .clk(clk), .rst(rst), .link(lnk.dev), .protect_sel(protect_sel), .cycle_running_flag(cycle_running_flag),
    .write_unlock_latch(write_unlock_latch), .rd_addr(rd_addr), .rd_data(rd_data));
  sfs_host_ctrl #(.PUW_CYCLES(50)) u_sfs_host_ctrl (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link(lnk.host));
  sfs_link_assertions u_sfs_link_assertions (
    .clk(clk), .rst(rst), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .mosi(lnk.mosi), .miso(lnk.miso),
    .miso_oe(lnk.miso_oe), .cycle_running_flag(cycle_running_flag), .write_unlock_latch(write_unlock_latch));
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic waitbit(input int b, input logic v);
    logic [31:0] s;
    int n;
    n = 0;
    rd(REG_STAT, s);
    while (s[b] !== v && n < 20000) begin
      rd(REG_STAT, s);
      n++;
    end
    if (n >= 20000) fails++;
  endtask : waitbit
  task automatic frame(input logic [7:0] op, input int ab, input int nd, input logic rdm, input logic [23:0] adr);
    logic [31:0] s;
    rxq = {};
    wr(REG_ADDR, {8'h00, adr});
    if (nd > 0 && !rdm) wr(REG_TX, {24'h0, txq[0]});
    wr(REG_CTRL, {11'h0, rdm, nd[9:0], ab[1:0], op});
    for (int i = rdm ? 0 : 1; i < nd; i++) begin
      if (rdm) begin
        waitbit(2, 1'b1);
        rd(REG_RX, s);
        rxq.push_back(s[7:0]);
      end else begin
        waitbit(1, 1'b0);
        wr(REG_TX, {24'h0, txq[i]});
      end
    end
    waitbit(0, 1'b0);
  endtask : frame
  task automatic unlock(input logic exp);
    frame(OP_UNLOCK, 0, 0, 1'b0, 24'h0);
    chk({31'h0, write_unlock_latch}, {31'h0, exp});
  endtask : unlock
  task automatic run();
    int n;
    n = 0;
    chk({31'h0, cycle_running_flag}, 32'h1);
    chk({31'h0, write_unlock_latch}, 32'h0);
    while (cycle_running_flag !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 20000, 32'h1);
  endtask : run
  task automatic mem(input logic [11:0] a, input logic [7:0] e);
    rd_addr <= a;
    @(posedge clk);
    #1;
    chk({24'h0, rd_data}, {24'h0, e});
    @(posedge clk);
  endtask : mem
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, cycle_running_flag, write_unlock_latch}, 32'h0);
    waitbit(3, 1'b1);
    unlock(1'b0);
    repeat (400) @(posedge clk);
    protect_sel <= 3'h1;
    unlock(1'b1);
    frame(OP_ARRAY, 0, 0, 1'b0, 24'h0);
    chk({31'h0, cycle_running_flag}, 32'h0);
    protect_sel <= 3'h0;
    frame(OP_ARRAY, 0, 0, 1'b0, 24'h0);
    run();
    mem(12'h000, 8'hff);
    mem(12'hfff, 8'hff);
    txq = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
    unlock(1'b1);
    frame(OP_PAGE, 3, 4, 1'b0, 24'h0000fe);
    run();
    mem(12'h0fe, 8'ha1);
    mem(12'h0ff, 8'hb2);
    mem(12'h000, 8'hc3);
    mem(12'h001, 8'hd4);
    mem(12'h002, 8'hff);
    frame(OP_PAGE, 3, 4, 1'b0, 24'h000010);
    chk({31'h0, cycle_running_flag}, 32'h0);
    mem(12'h010, 8'hff);
    txq = '{8'h5c};
    unlock(1'b1);
    frame(OP_PAGE, 3, 1, 1'b0, 24'h000e00);
    run();
    protect_sel <= 3'h1;
    unlock(1'b1);
    frame(OP_PAGE, 3, 1, 1'b0, 24'h000c10);
    chk({31'h0, cycle_running_flag}, 32'h0);
    frame(OP_SECTOR, 3, 0, 1'b0, 24'h000e55);
    chk({31'h0, cycle_running_flag}, 32'h0);
    mem(12'he00, 8'h5c);
    mem(12'hc10, 8'hff);
    protect_sel <= 3'h0;
    // host sends whole bytes only, so bad framings are wrong byte counts
    for (int i = 0; i < 4; i++) begin
      frame(bad_op[i], bad_ab[i], bad_nd[i], 1'b0, 24'h000400);
      chk({31'h0, cycle_running_flag}, 32'h0);
    end
    frame(OP_SECTOR, 3, 0, 1'b0, 24'h000123);
    run();
    mem(12'h0fe, 8'hff);
    mem(12'h000, 8'hff);
    mem(12'he00, 8'h5c);
    txq = {};
    for (int k = 0; k <= 256; k++) txq.push_back(k == 256 ? 8'h0f : k[7:0]);
    unlock(1'b1);
    frame(OP_PAGE, 3, 257, 1'b0, 24'h000200);
    run();
    mem(12'h200, 8'h0f);
    mem(12'h201, 8'h01);
    mem(12'h2ff, 8'hff);
    frame(OP_SIG, 3, 2, 1'b1, 24'h0);
    chk({24'h0, rxq[0]}, {24'h0, SIG_VALUE});
    chk({24'h0, rxq[1]}, {24'h0, SIG_VALUE});
    frame(OP_SIG, 1, 0, 1'b0, 24'h0);
    unlock(1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, write_unlock_latch}, 32'h0);
    rst <= 1'b0;
    conclude();
  end
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : serial_flash_program_erase_sequencer_tb_top
`default_nettype wire
